// *** common/hpd_pkg.sv ***
// Package of constants and carrier types for the host port mode and cycle decode block.
//
// Contract
// [RULE_01] Select 00x gives 8080 parallel port.
// [RULE_02] Select 01x gives 6800 parallel port.
// [RULE_03] Select 100 three-wire SPI, 101 four-wire.
// [RULE_04] Select 11x gives IIC serial port.
// [RULE_05] Select low: status read, command write.
// [RULE_06] Select high: data read and write.
// [RULE_07] Chip select low addresses; high ignored.
// [RULE_08] 8080: read pin is active-low read.
// [RULE_09] 6800: read pin is active-high enable.
// [RULE_10] 8080: write pin is active-low write.
// [RULE_11] 6800: write pin high read, low write.
// [RULE_12] Wait high ready, low holds host.
// [RULE_13] Upper data byte is port A unless 16-bit.
// [RULE_14] Serial mode reuses lower byte as serial pins.
// [RULE_15] Serial mode: strobe pins read as bank B.
// [RULE_16] Parallel mode: select bit 0 is interrupt.
// [RULE_17] Interrupt output signals pending status.
// [RULE_18] Data bus bidirectional, sixteen bits wide.
// [RULE_19] Interrupt low while enabled condition pends.
// [RULE_20] Select pins latched at reset release.
`default_nettype none
package hpd_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int SEL_W = 3;
  localparam int IRQ_W = 8;

  localparam logic [1:0] SEL_8080 = 2'h0;
  localparam logic [1:0] SEL_6800 = 2'h1;
  localparam logic [1:0] SEL_SPI = 2'h2;
  localparam logic [1:0] SEL_IIC = 2'h3;
  localparam int SEL_LOW_BIT = 0;

  // Serial pin positions on the lower data byte.
  localparam int SER_CLK_BIT = 7;
  localparam int SER_DIN_BIT = 6;
  localparam int SER_DIO_BIT = 5;
  localparam int SER_CS_BIT = 4;

  typedef enum logic [2:0] {
    HPD_M_8080 = 3'h0,
    HPD_M_6800 = 3'h1,
    HPD_M_SPI3 = 3'h3,
    HPD_M_SPI4 = 3'h2,
    HPD_M_IIC = 3'h6
  } hpd_mode_t;

  typedef enum logic [1:0] {
    HPD_IDLE = 2'h0,
    HPD_ACT = 2'h1,
    HPD_WAIT = 2'h3,
    HPD_DONE = 2'h2
  } hpd_state_t;

  typedef enum logic [1:0] {
    HPD_C_STATUS_RD = 2'h0,
    HPD_C_CMD_WR = 2'h1,
    HPD_C_DATA_RD = 2'h2,
    HPD_C_DATA_WR = 2'h3
  } hpd_cycle_t;

  typedef struct packed {
    logic cs_n;
    logic cmd_data_select;
    logic read_or_enable_pin;
    logic write_or_dir_pin;
  } hpd_ctl_t;

  typedef struct packed {
    logic valid;
    hpd_cycle_t kind;
    logic [DATA_W-1:0] data;
  } hpd_req_t;

  typedef struct packed {
    logic sclk;
    logic sdin;
    logic sdio_in;
    logic scs_n;
    logic [3:0] addr_sel;
  } hpd_ser_t;
endpackage
`default_nettype wire

// *** design/hpd_sync_reg.sv ***
// Plain register with reset value, used for the data bus value and output enable stages.
`default_nettype none
module hpd_sync_reg #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_q <= RST_VAL;
    end else begin
      o_q <= i_d;
    end
  end
endmodule
`default_nettype wire

// *** design/hpd_mode_latch.sv ***
// Latches the host interface select pins once after reset release.
`default_nettype none
module hpd_mode_latch
  import hpd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [SEL_W-1:0] i_sel,
  output hpd_mode_t o_mode,
  output logic o_locked
);
  // ----------------------------------------------------------------
  // Mode capture
  // ----------------------------------------------------------------
  // The pins are caught on the first clock after release, never by the reset itself.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mode <= HPD_M_8080;
      o_locked <= 1'b0;
    end else if (!o_locked) begin
      o_locked <= 1'b1;
      // [RULE_20] one-time capture
      case (i_sel[SEL_W-1 -: 2])
        // [RULE_01] 8080 decode
        SEL_8080: o_mode <= HPD_M_8080;
        // [RULE_02] 6800 decode
        SEL_6800: o_mode <= HPD_M_6800;
        // [RULE_03] SPI decode
        SEL_SPI: o_mode <= i_sel[SEL_LOW_BIT] ? HPD_M_SPI4 : HPD_M_SPI3;
        // [RULE_04] IIC decode
        SEL_IIC: o_mode <= HPD_M_IIC;
        default: o_mode <= HPD_M_8080;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** design/hpd_host_port.sv ***
// Top of the host port: mode select, cycle decode, wait, interrupt and pin reuse.
`default_nettype none
module hpd_host_port
  import hpd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [SEL_W-1:0] i_host_if_select,
  input wire logic i_bus16,
  input wire logic i_host_chip_sel_n,
  input wire logic i_cmd_data_select,
  input wire logic i_read_or_enable_pin,
  input wire logic i_write_or_dir_pin,
  input wire logic [DATA_W-1:0] i_host_data_bus,
  output logic [DATA_W-1:0] o_host_data_bus,
  output logic [DATA_W-1:0] o_host_data_bus_oe_n,
  output logic o_host_wait_n,
  output logic o_host_irq_n,
  input wire logic i_core_ready,
  input wire logic [DATA_W-1:0] i_status,
  input wire logic [DATA_W-1:0] i_rd_data,
  output hpd_req_t o_req,
  input wire logic [IRQ_W-1:0] i_irq_pending,
  input wire logic [IRQ_W-1:0] i_irq_enable,
  output logic o_ext_irq,
  input wire logic [BYTE_W-1:0] i_port_a_out,
  input wire logic [BYTE_W-1:0] i_port_a_dir,
  output logic [BYTE_W-1:0] o_port_a_in,
  output logic [2:0] o_input_bank_b,
  output hpd_ser_t o_serial,
  input wire logic i_serial_dout,
  input wire logic i_serial_dout_oe_n,
  output hpd_mode_t o_mode,
  output logic o_mode_valid
);
  hpd_mode_t mode;
  logic locked;
  logic parallel;
  logic serial;
  logic rd_act;
  logic wr_act;
  logic cyc_act;
  hpd_state_t state;
  hpd_state_t next_state;
  hpd_ctl_t ctl;
  logic cyc_read;
  logic [DATA_W-1:0] drive_data;
  logic [DATA_W-1:0] next_oe_n;
  logic [DATA_W-1:0] next_dout;
  logic next_irq_n;
  logic [DATA_W-1:0] out_q;
  logic [DATA_W-1:0] oe_q;

  hpd_mode_latch u_mode (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sel(i_host_if_select),
    .o_mode(mode),
    .o_locked(locked)
  );

  assign parallel = locked && (mode == HPD_M_8080 || mode == HPD_M_6800);
  assign serial = locked && !parallel;
  assign ctl = '{cs_n: i_host_chip_sel_n, cmd_data_select: i_cmd_data_select,
                 read_or_enable_pin: i_read_or_enable_pin,
                 write_or_dir_pin: i_write_or_dir_pin};

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (parallel && !ctl.cs_n) begin
      if (mode == HPD_M_8080) begin
        // [RULE_08] active-low read
        rd_act = !ctl.read_or_enable_pin;
        // [RULE_10] active-low write
        wr_act = !ctl.write_or_dir_pin;
      end else begin
        // [RULE_09] enable qualifies
        // [RULE_11] direction select
        rd_act = ctl.read_or_enable_pin && ctl.write_or_dir_pin;
        wr_act = ctl.read_or_enable_pin && !ctl.write_or_dir_pin;
      end
    end
  end
  // [RULE_07] chip select gating
  assign cyc_act = rd_act || wr_act;

  // ----------------------------------------------------------------
  // Cycle state machine
  // ----------------------------------------------------------------
  // A transfer is issued once per strobe; the state holds until the strobe ends.
  always_comb begin
    next_state = state;
    case (state)
      HPD_IDLE: begin
        if (cyc_act) begin
          next_state = i_core_ready ? HPD_ACT : HPD_WAIT;
        end
      end
      HPD_WAIT: begin
        if (!cyc_act) begin
          next_state = HPD_IDLE;
        end else if (i_core_ready) begin
          next_state = HPD_ACT;
        end
      end
      HPD_ACT: next_state = HPD_DONE;
      HPD_DONE: begin
        if (!cyc_act) begin
          next_state = HPD_IDLE;
        end
      end
      default: next_state = HPD_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= HPD_IDLE;
      cyc_read <= 1'b0;
    end else begin
      state <= next_state;
      if (state == HPD_IDLE && cyc_act) begin
        cyc_read <= rd_act;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request to the core
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_req <= '0;
    end else begin
      o_req.valid <= (next_state == HPD_ACT);
      if (next_state == HPD_ACT) begin
        // [RULE_05] status or command
        // [RULE_06] data access
        case ({ctl.cmd_data_select, rd_act})
          2'b01: o_req.kind <= HPD_C_STATUS_RD;
          2'b00: o_req.kind <= HPD_C_CMD_WR;
          2'b11: o_req.kind <= HPD_C_DATA_RD;
          default: o_req.kind <= HPD_C_DATA_WR;
        endcase
        o_req.data <= i_bus16 ? i_host_data_bus
                              : {{BYTE_W{1'b0}}, i_host_data_bus[BYTE_W-1:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Wait output
  // ----------------------------------------------------------------
  // Wait drops on the clock edge after a strobe meets a busy core, and rises on the edge that issues the access.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_wait_n <= 1'b1;
    end else begin
      // [RULE_12] hold host off
      o_host_wait_n <= !(next_state == HPD_WAIT);
    end
  end

  // ----------------------------------------------------------------
  // Data bus drive and pin reuse
  // ----------------------------------------------------------------
  assign drive_data = ctl.cmd_data_select ? i_rd_data : i_status;

  always_comb begin
    next_oe_n = '1;
    next_dout = '0;
    // [RULE_18] bidirectional bus
    // On the edge that leaves idle the registered direction still belongs to the last cycle.
    if (parallel && (state == HPD_IDLE ? rd_act : cyc_read) &&
        (next_state == HPD_ACT || next_state == HPD_DONE)) begin
      next_oe_n[BYTE_W-1:0] = '0;
      next_dout[BYTE_W-1:0] = drive_data[BYTE_W-1:0];
      if (i_bus16) begin
        next_oe_n[DATA_W-1:BYTE_W] = '0;
        next_dout[DATA_W-1:BYTE_W] = drive_data[DATA_W-1:BYTE_W];
      end
    end
    // [RULE_13] upper byte as port A
    if (locked && !(parallel && i_bus16)) begin
      next_oe_n[DATA_W-1:BYTE_W] = ~i_port_a_dir;
      next_dout[DATA_W-1:BYTE_W] = i_port_a_out;
    end
    // [RULE_14] serial data out pin
    if (serial) begin
      next_oe_n[SER_DIO_BIT] = i_serial_dout_oe_n;
      next_dout[SER_DIO_BIT] = i_serial_dout;
    end
  end

  hpd_sync_reg #(.W(DATA_W), .RST_VAL('0)) u_dout (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(next_dout),
    .o_q(out_q)
  );

  hpd_sync_reg #(.W(DATA_W), .RST_VAL('1)) u_oe (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(next_oe_n),
    .o_q(oe_q)
  );

  assign o_host_data_bus = out_q;
  assign o_host_data_bus_oe_n = oe_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_a_in <= '0;
      o_input_bank_b <= '0;
      o_serial <= '0;
    end else begin
      if (locked && !(parallel && i_bus16)) begin
        o_port_a_in <= i_host_data_bus[DATA_W-1:BYTE_W];
      end
      if (serial) begin
        // [RULE_15] strobe pins as bank B
        o_input_bank_b <= {ctl.write_or_dir_pin, ctl.read_or_enable_pin, ctl.cs_n};
        // [RULE_14] serial pin map
        o_serial <= '{sclk: i_host_data_bus[SER_CLK_BIT],
                      sdin: i_host_data_bus[SER_DIN_BIT],
                      sdio_in: i_host_data_bus[SER_DIO_BIT],
                      scs_n: i_host_data_bus[SER_CS_BIT],
                      addr_sel: i_host_data_bus[3:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // [RULE_19] low while enabled pends
  // [RULE_17] interrupt to host
  assign next_irq_n = ~|(i_irq_pending & i_irq_enable);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_irq_n <= 1'b1;
      o_ext_irq <= 1'b0;
      o_mode <= HPD_M_8080;
      o_mode_valid <= 1'b0;
    end else begin
      o_host_irq_n <= next_irq_n;
      // [RULE_16] select bit 0 as interrupt
      o_ext_irq <= parallel && i_host_if_select[SEL_LOW_BIT];
      o_mode <= mode;
      o_mode_valid <= locked;
    end
  end
endmodule
`default_nettype wire

// *** test/hpd_host_model.sv ***
// Behavioural host processor that drives the parallel host pins.
`default_nettype none
module hpd_host_model (
  input wire logic i_clk,
  input wire logic i_m6800,
  input wire logic i_wait_n,
  input wire logic [15:0] i_bus,
  output logic o_cs_n,
  output logic o_a0,
  output logic o_rde,
  output logic o_wrd,
  output logic [15:0] o_d
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle pins; released data lines show inverted stale data.
  task automatic idle();
    o_cs_n = 1'b1;
    o_rde = (i_m6800 !== 1'b1);
    o_wrd = 1'b1;
    o_d = ~o_d;
  endtask
  initial begin
    o_a0 = 1'b0;
    o_d = 16'h0000;
    idle();
  end
  // Strobe held until wait is seen high.
  task automatic xfer(input logic cs, input logic wr, input logic a0, input logic [15:0] wd,
    output logic [15:0] rd, output int n);
    @(posedge i_clk);
    #2;
    o_cs_n = !cs;
    o_a0 = a0;
    o_wrd = !wr;
    o_rde = i_m6800 | wr;
    if (wr)
      o_d = wd;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while ((n < 2 || i_wait_n !== 1'b1) && n < 40);
    rd = i_bus;
    #2;
    idle();
  endtask
endmodule
`default_nettype wire

// *** test/hpd_host_port_assertions.sv ***
// Concurrent checks on the host port top, bound below.
`default_nettype none
module hpd_host_port_checker
  import hpd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [SEL_W-1:0] i_host_if_select,
  input wire logic i_bus16,
  input wire logic i_host_chip_sel_n,
  input wire logic i_cmd_data_select,
  input wire logic i_write_or_dir_pin,
  input wire logic [DATA_W-1:0] i_host_data_bus,
  input wire logic [DATA_W-1:0] o_host_data_bus,
  input wire logic [DATA_W-1:0] o_host_data_bus_oe_n,
  input wire logic o_host_wait_n,
  input wire logic o_host_irq_n,
  input wire logic i_core_ready,
  input wire logic [DATA_W-1:0] i_status,
  input wire logic [DATA_W-1:0] i_rd_data,
  input wire hpd_req_t o_req,
  input wire logic [IRQ_W-1:0] i_irq_pending,
  input wire logic [IRQ_W-1:0] i_irq_enable,
  input wire hpd_mode_t o_mode,
  input wire logic o_mode_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic [DATA_W-1:0] mask;
  hpd_mode_t want;
  // In 8-bit mode the upper byte belongs to port A, so only the low byte pairs.
  assign mask = i_bus16 ? 16'hffff : 16'h00ff;
  always_comb begin
    want = HPD_M_IIC;
    if (!i_host_if_select[2])
      want = i_host_if_select[1] ? HPD_M_6800 : HPD_M_8080;
    else if (!i_host_if_select[1])
      want = i_host_if_select[0] ? HPD_M_SPI4 : HPD_M_SPI3;
  end
  sequence s_locked;
    $rose(o_mode_valid);
  endsequence
  a_mode_decode:
    assert property (s_locked |-> o_mode == $past(want)) else $error("mode differs from pins");
  a_mode_hold:
    assert property (o_mode_valid |=> o_mode_valid && $stable(o_mode)) else $error("mode moved");
  a_irq_level:
    assert property (1 |=> o_host_irq_n == !$past(|(i_irq_pending & i_irq_enable)))
    else $error("interrupt output wrong");
  a_wait_cause:
    assert property (!o_host_wait_n |-> !$past(i_host_chip_sel_n) && !$past(i_core_ready))
    else $error("wait low without pending strobe");
  a_req_cause:
    assert property (o_req.valid |-> !$past(i_host_chip_sel_n) && !o_mode[2] && !o_mode[1])
    else $error("request without chip select");
  a_req_kind:
    assert property (o_req.valid |->
      o_req.kind == {$past(i_cmd_data_select), !$past(i_write_or_dir_pin)})
    else $error("request kind wrong");
  a_wr_data:
    assert property (o_req.valid && o_req.kind[0] |-> o_req.data == ($past(i_host_data_bus) & mask))
    else $error("write data wrong");
  a_rd_drive:
    assert property (o_req.valid && !o_req.kind[0] |-> o_host_data_bus_oe_n == ~mask &&
      o_host_data_bus == ((o_req.kind[1] ? i_rd_data : i_status) & mask))
    else $error("read drive wrong");
endmodule
bind hpd_host_port hpd_host_port_checker i_hpd_host_port_checker (.*);
`default_nettype wire

// *** test/test_hpd_host_port.sv ***
// Directed testbench for the host port block driven by a host model.
`default_nettype none
module test_hpd_host_port
  import hpd_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0, i_rst = 1'b1, i_bus16 = 1'b1, i_core_ready = 1'b1, i_serial_dout = 1'b0;
  logic i_serial_dout_oe_n = 1'b1, i_host_chip_sel_n, i_cmd_data_select, i_read_or_enable_pin;
  logic i_write_or_dir_pin, o_host_wait_n, o_host_irq_n, o_ext_irq, o_mode_valid;
  logic [2:0] i_host_if_select = 3'h0, o_input_bank_b;
  logic [7:0] i_irq_pending = 8'h81, i_irq_enable = 8'h00, i_port_a_out = 8'h00;
  logic [7:0] i_port_a_dir = 8'h00, o_port_a_in;
  logic [15:0] i_status = 16'h5a3c, i_rd_data = 16'hc3e1, i_host_data_bus, o_host_data_bus;
  logic [15:0] o_host_data_bus_oe_n, hd, rd;
  hpd_req_t o_req, last;
  hpd_ser_t o_serial;
  hpd_mode_t o_mode;
  int fails = 0, checked = 0, nreq = 0, n, c;
  hpd_mode_t em[8] = '{HPD_M_8080, HPD_M_8080, HPD_M_6800, HPD_M_6800, HPD_M_SPI3, HPD_M_SPI4,
    HPD_M_IIC, HPD_M_IIC};
  assign i_host_data_bus = (~o_host_data_bus_oe_n & o_host_data_bus) | (o_host_data_bus_oe_n & hd);
  hpd_host_port i_hpd_host_port (.*);
  hpd_host_model i_hpd_host_model (.i_clk(i_clk), .i_m6800(i_host_if_select[2:1] == 2'h1),
    .i_wait_n(o_host_wait_n), .i_bus(i_host_data_bus), .o_cs_n(i_host_chip_sel_n),
    .o_a0(i_cmd_data_select), .o_rde(i_read_or_enable_pin), .o_wrd(i_write_or_dir_pin),
    .o_d(hd));
  initial forever #25 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    if (o_req.valid === 1'b1) begin
      nreq++;
      last = o_req;
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] s);
    @(posedge i_clk);
    #2;
    i_rst = 1'b1;
    i_host_if_select = s;
    repeat (3) @(posedge i_clk);
    #2;
    i_rst = 1'b0;
    repeat (3) @(posedge i_clk);
    #2;
  endtask
  task automatic go(input logic cs, input logic wr, input logic a0, input logic [15:0] w);
    i_hpd_host_model.xfer(cs, wr, a0, w, rd, n);
    if (n >= 40) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic four(input logic [2:0] s);
    logic [15:0] m, w;
    int c0;
    m = i_bus16 ? 16'hffff : 16'h00ff;
    do_reset(s);
    for (int k = 0; k < 4; k++) begin
      w = 16'ha5c3 ^ 16'(k);
      c0 = nreq;
      go(1'b1, k[0], k[1], w);
      check(16'(nreq - c0), 16'h0001);
      check(last.kind, k[1:0]);
      check(k[0] ? last.data : (rd & m), (k[0] ? w : k[1] ? i_rd_data : i_status) & m);
    end
  endtask
  initial begin
    for (int k = 0; k < 8; k++) begin
      do_reset(k[2:0]);
      check({o_mode_valid, o_mode}, {1'b1, em[k]});
      check(o_ext_irq, k < 4 && k[0]);
    end
    four(3'h0);
    four(3'h2);
    c = nreq;
    go(1'b0, 1'b1, 1'b1, 16'h1234);
    check(16'(nreq - c), 16'h0000);
    i_core_ready = 1'b0;
    fork
      go(1'b1, 1'b0, 1'b1, 16'h0000);
      begin
        repeat (6) @(posedge i_clk);
        #2 i_core_ready = 1'b1;
      end
    join
    check(n > 6, 1'b1);
    check(rd, i_rd_data);
    i_bus16 = 1'b0;
    four(3'h0);
    repeat (2) @(posedge i_clk);
    #2 check(o_port_a_in, i_host_data_bus[15:8]);
    i_port_a_dir = 8'hff;
    i_port_a_out = 8'h96;
    repeat (2) @(posedge i_clk);
    #2 check({o_host_data_bus_oe_n[15:8], o_host_data_bus[15:8]}, 16'h0096);
    c = nreq;
    do_reset(3'h5);
    fork
      go(1'b1, 1'b1, 1'b0, 16'h00a6);
      begin
        repeat (2) @(posedge i_clk);
        #3 check(o_serial, 16'h00a6);
        check(o_input_bank_b, 3'h2);
      end
    join
    check(16'(nreq - c), 16'h0000);
    i_serial_dout_oe_n = 1'b0;
    i_serial_dout = 1'b1;
    repeat (2) @(posedge i_clk);
    #2 check({o_host_data_bus_oe_n[5], o_host_data_bus[5]}, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      i_irq_enable = k ? 8'h7e : 8'h01;
      repeat (2) @(posedge i_clk);
      #2 check(o_host_irq_n, k[0]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
